// ---- rtl/sgc_global_regs.sv ----
`include "sgc_map.svh"

module sgc_global_regs #(
  parameter int NUM_PORTS = 3,
  parameter int unsigned PERIOD_FAST_CYC = `SGC_PERIOD_100M_MS * `SGC_CLK_KHZ,
  parameter int unsigned PERIOD_SLOW_CYC = `SGC_PERIOD_10M_MS * `SGC_CLK_KHZ
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire sgc_pkg::sgc_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [NUM_PORTS-1:0] bcast_blk,
  input wire logic [NUM_PORTS-1:0] port_is_10m,
  output logic [NUM_PORTS-1:0] storm_drop,
  input wire sgc_pkg::sgc_tag_in_type tag_in,
  output logic [1:0] frame_priority,
  output logic frame_priority_valid,
  output sgc_pkg::sgc_clk_code_type host_clk_sel
);

  logic [6:0] storm_hi_r;
  logic [7:0] storm_lo_r;
  sgc_pkg::sgc_clk_code_type clk_sel_r;
  logic [7:0] prio_lo_r;
  logic [7:0] prio_hi_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [1:0] prio_r;
  logic prio_valid_r;
  logic [NUM_PORTS-1:0] drop_w;

  ////////////////////////////////////////////////////////////////
  // Decode
  wire wr_hi = reg_req.wr && (reg_req.addr == `SGC_OFS_STORM_HI);
  wire wr_lo = reg_req.wr && (reg_req.addr == `SGC_OFS_STORM_LO);
  wire wr_clk = reg_req.wr && (reg_req.addr == `SGC_OFS_CLK_SEL);
  wire wr_plo = reg_req.wr && (reg_req.addr == `SGC_OFS_PRIO_LO);
  wire wr_phi = reg_req.wr && (reg_req.addr == `SGC_OFS_PRIO_HI);
  wire [1:0] clk_code_in = reg_req.wdata[`SGC_CLK_SEL_MSB:`SGC_CLK_SEL_LSB];
  wire clk_code_ok = (clk_code_in != 2'h3);
  wire [10:0] threshold = {storm_hi_r[`SGC_STORM_HI_MSB:0], storm_lo_r};
  wire [15:0] prio_all = {prio_hi_r, prio_lo_r};
  wire [1:0] prio_sel = prio_all[{tag_in.tag, 1'b0} +: 2];

  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (reg_req.addr)
      `SGC_OFS_STORM_HI: rd_mux = {1'b0, storm_hi_r};
      `SGC_OFS_STORM_LO: rd_mux = storm_lo_r;
      `SGC_OFS_FTEST_A: rd_mux = `SGC_RST_FTEST_A;
      `SGC_OFS_FTEST_B: rd_mux = `SGC_RST_FTEST_B;
      `SGC_OFS_FTEST_C: rd_mux = `SGC_RST_FTEST_C;
      `SGC_OFS_CLK_SEL: rd_mux = {clk_sel_r, `SGC_RST_CLK_LOW};
      `SGC_OFS_PRIO_LO: rd_mux = prio_lo_r;
      `SGC_OFS_PRIO_HI: rd_mux = prio_hi_r;
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      storm_hi_r <= 7'(`SGC_RST_STORM_HI);
      storm_lo_r <= `SGC_RST_STORM_LO;
      clk_sel_r <= sgc_pkg::sgc_clk_code_type'(`SGC_RST_CLK_CODE);
      prio_lo_r <= `SGC_RST_PRIO_LO;
      prio_hi_r <= `SGC_RST_PRIO_HI;
    end
    else
    begin
      // Bit 7 of the high register is read-only zero
      if (wr_hi)
        storm_hi_r <= reg_req.wdata[`SGC_STORM_HI_RW_MSB:0];
      if (wr_lo)
        storm_lo_r <= reg_req.wdata;
      if (wr_clk && clk_code_ok)
        clk_sel_r <= sgc_pkg::sgc_clk_code_type'(clk_code_in);
      if (wr_plo)
        prio_lo_r <= reg_req.wdata;
      if (wr_phi)
        prio_hi_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= reg_req.rd;
      if (reg_req.rd)
        rdata_r <= rd_mux;
    end
  end

  // Priority answer one cycle after the tag
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prio_r <= 2'h0;
      prio_valid_r <= 1'b0;
    end
    else
    begin
      prio_valid_r <= tag_in.valid;
      if (tag_in.valid)
        prio_r <= prio_sel;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per port storm meters; drop is already a flop inside
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      sgc_storm_meter #(
        .PERIOD_FAST_CYC(PERIOD_FAST_CYC),
        .PERIOD_SLOW_CYC(PERIOD_SLOW_CYC),
        .CNT_W(26)
      ) u_meter (
        .clk_sys(clk_sys),
        .srst(srst),
        .is_10m(port_is_10m[p]),
        .blk(bcast_blk[p]),
        .threshold(threshold),
        .drop(drop_w[p])
      );
    end
  endgenerate

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign storm_drop = drop_w;
  assign frame_priority = prio_r;
  assign frame_priority_valid = prio_valid_r;
  assign host_clk_sel = clk_sel_r;

endmodule : sgc_global_regs

// ---- common/sgc_map.svh ----
`ifndef SGC_MAP_SVH
`define SGC_MAP_SVH

// Register offsets
`define SGC_OFS_STORM_HI 8'h06
`define SGC_OFS_STORM_LO 8'h07
`define SGC_OFS_FTEST_A 8'h08
`define SGC_OFS_FTEST_B 8'h09
`define SGC_OFS_FTEST_C 8'h0a
`define SGC_OFS_CLK_SEL 8'h0b
`define SGC_OFS_PRIO_LO 8'h0c
`define SGC_OFS_PRIO_HI 8'h0d

// Reset values
`define SGC_RST_STORM_HI 8'h20
`define SGC_RST_STORM_LO 8'h63
`define SGC_RST_FTEST_A 8'h00
`define SGC_RST_FTEST_B 8'h24
`define SGC_RST_FTEST_C 8'h35
`define SGC_RST_CLK_CODE 2'h2
`define SGC_RST_CLK_LOW 6'h08
`define SGC_RST_PRIO_LO 8'h50
`define SGC_RST_PRIO_HI 8'hfa

// Field positions
`define SGC_STORM_HI_MSB 2
`define SGC_STORM_HI_RW_MSB 6
`define SGC_CLK_SEL_MSB 7
`define SGC_CLK_SEL_LSB 6

// Timing
`define SGC_CLK_KHZ 100000
`define SGC_PERIOD_100M_MS 67
`define SGC_PERIOD_10M_MS 500

`endif

// ---- common/sgc_pkg.sv ----
package sgc_pkg;

  typedef enum logic [1:0] {
    SGC_CLK_31M25 = 2'h0,
    SGC_CLK_62M5 = 2'h1,
    SGC_CLK_125M = 2'h2,
    SGC_CLK_RSVD = 2'h3
  } sgc_clk_code_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sgc_reg_req_type;

  typedef struct packed {
    logic valid;
    logic [2:0] tag;
  } sgc_tag_in_type;

endpackage : sgc_pkg

// ---- rtl/sgc_storm_meter.sv ----
module sgc_storm_meter #(
  parameter int unsigned PERIOD_FAST_CYC = 6700000,
  parameter int unsigned PERIOD_SLOW_CYC = 50000000,
  parameter int CNT_W = 26
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic is_10m,
  input wire logic blk,
  input wire logic [10:0] threshold,
  output logic drop
);

  logic [CNT_W-1:0] tick_r;
  logic [10:0] blocks_r;
  logic drop_r;
  wire [CNT_W-1:0] last_fast = CNT_W'(PERIOD_FAST_CYC - 1);
  wire [CNT_W-1:0] last_slow = CNT_W'(PERIOD_SLOW_CYC - 1);
  wire period_end = (tick_r >= (is_10m ? last_slow : last_fast));
  wire at_limit = (blocks_r >= threshold);
  wire [10:0] blocks_nxt = blocks_r + 11'h001;
  // Drop tracks the next count, so it clears at period end in the same cycle the count restarts from blk
  wire [10:0] count_nxt = period_end ? {10'h000, blk}
    : ((blk && !at_limit) ? blocks_nxt : blocks_r);

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tick_r <= '0;
      blocks_r <= 11'h000;
      drop_r <= 1'b0;
    end
    else
    begin
      tick_r <= period_end ? '0 : tick_r + CNT_W'(1);
      blocks_r <= count_nxt;
      drop_r <= (count_nxt >= threshold);
    end
  end

  assign drop = drop_r;

endmodule : sgc_storm_meter

// ---- test/sgc_global_regs_properties.sv ----
module sgc_global_regs_properties #(
  parameter int NUM_PORTS = 3
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire sgc_pkg::sgc_reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [NUM_PORTS-1:0] bcast_blk,
  input wire logic [NUM_PORTS-1:0] storm_drop,
  input wire sgc_pkg::sgc_tag_in_type tag_in,
  input wire logic frame_priority_valid,
  input wire sgc_pkg::sgc_clk_code_type host_clk_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_clk_wr;
    reg_req.wr && reg_req.addr == 8'h0b && reg_req.wdata[7:6] != 2'h3;
  endsequence
  chk_rvalid_after_rd: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data moved");
  chk_clk_write: assert property (s_clk_wr |=> host_clk_sel == $past(reg_req.wdata[7:6]))
    else $error("clock code not taken");
  chk_clk_stable: assert property (!(reg_req.wr && reg_req.addr == 8'h0b)
    |=> $stable(host_clk_sel))
    else $error("clock code moved");
  chk_clk_rsvd: assert property (host_clk_sel != sgc_pkg::SGC_CLK_RSVD)
    else $error("reserved clock code");
  chk_drop_cause: assert property ($rose(storm_drop[0]) |-> $past(bcast_blk[0]))
    else $error("drop without block");
  chk_prio_pulse: assert property (tag_in.valid |=> frame_priority_valid)
    else $error("priority not answered");
  chk_prio_quiet: assert property (!tag_in.valid |=> !frame_priority_valid)
    else $error("spurious priority");
endmodule : sgc_global_regs_properties
////////////////////////////////////////////////////////////////////////////////
bind sgc_global_regs sgc_global_regs_properties #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .clk_sys, .srst, .reg_req, .reg_rdata, .reg_rvalid, .bcast_blk, .storm_drop,
  .tag_in, .frame_priority_valid, .host_clk_sel);

// ---- test/sgc_global_regs_tb_top.sv ----
module sgc_global_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short periods keep the storm runs brief
  localparam int PF = 20;
  localparam int PS = 50;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  sgc_pkg::sgc_reg_req_type req = '0;
  sgc_pkg::sgc_tag_in_type tag = '0;
  logic [2:0] blk = 3'b000;
  logic [2:0] drop;
  logic [7:0] rdata, d, plo, phi;
  logic [1:0] prio, e;
  sgc_pkg::sgc_clk_code_type csel;
  logic [31:0] seed = 32'h31be576b;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int n, m;
  sgc_global_regs #(.PERIOD_FAST_CYC(PF), .PERIOD_SLOW_CYC(PS)) DUT (
    .clk_sys(clk_sys), .srst(srst), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(),
    .bcast_blk(blk), .port_is_10m(3'b010), .storm_drop(drop), .tag_in(tag),
    .frame_priority(prio), .frame_priority_valid(), .host_clk_sel(csel));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  function logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  function logic [7:0] rst_val(input int a);
    case (a)
      6: return 8'h20;
      7: return 8'h63;
      9: return 8'h24;
      10: return 8'h35;
      11: return 8'h88;
      12: return 8'h50;
      13: return 8'hfa;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  function logic [1:0] pmap(input int t);
    logic [15:0] v;
    v = {phi, plo} >> (2 * t);
    return v[1:0];
  endfunction : pmap
  task chk(input logic [7:0] g, input logic [7:0] x);
    check_count++;
    if (g !== x)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys) req <= '{1'b1, 1'b0, a, v};
    @(posedge clk_sys) req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys) req.rd <= 1'b0;
    @(negedge clk_sys) v = rdata;
  endtask : rd
  task snd(input logic [2:0] t);
    @(posedge clk_sys) tag <= '{1'b1, t};
    @(posedge clk_sys) tag.valid <= 1'b0;
    @(negedge clk_sys);
  endtask : snd
  // Phase of the period is unknown, so lock on a drop release first
  task meas(input int p, input int per);
    for (n = 0; drop[p] !== 1'b1 && n < 200; n++) @(negedge clk_sys);
    for (n = 0; drop[p] !== 1'b0 && n < 200; n++) @(negedge clk_sys);
    for (n = 0; drop[p] === 1'b0 && n < 200; n++) @(negedge clk_sys);
    for (m = 0; drop[p] === 1'b1 && m < 200; m++) @(negedge clk_sys);
    chk(8'(n), 8'h02);
    chk(8'(n + m), 8'(per));
  endtask : meas
  task end_of_test();
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 5; a < 15; a++)
    begin
      if (a inside {5, 14})
        wr(8'(a), xs());
      rd(8'(a), d);
      chk(d, rst_val(a));
    end
    wr(8'h06, 8'h80);
    rd(8'h06, d);
    chk(d, 8'h00);
    wr(8'h07, 8'h03);
    @(posedge clk_sys) blk <= 3'b111;
    meas(0, PF);
    meas(1, PS);
    meas(2, PF);
    wr(8'h06, 8'h01);
    repeat (60) @(negedge clk_sys);
    chk({5'h00, drop}, 8'h00);
    @(posedge clk_sys) blk <= 3'b000;
    for (int c = 0; c < 4; c++)
    begin
      e = (c == 3) ? 2'h2 : 2'(c);
      wr(8'h0b, {2'(c), 6'h3f});
      rd(8'h0b, d);
      chk(d, {e, 6'h08});
      chk({6'h00, csel}, {6'h00, e});
    end
    wr(8'h0b, 8'h08);
    @(negedge clk_sys);
    chk({6'h00, csel}, 8'h00);
    plo = xs();
    phi = xs();
    wr(8'h0c, plo);
    wr(8'h0d, phi);
    for (int t = 0; t < 8; t++)
    begin
      snd(3'(t));
      chk({6'h00, prio}, {6'h00, pmap(t)});
    end
    end_of_test();
  end
endmodule : sgc_global_regs_tb_top
